/* File: hdl/eep_pkg.sv */
// Shared constants and carrier types for the serial EEPROM slave
package eep_pkg;

  // ==========================================================================
  // Array geometry
  // ==========================================================================
  localparam int ADDR_W    = 16;          // Word address width, no don't-care bits
  localparam int PAGE_W    = 7;           // Low address bits that wrap inside a page
  localparam int BYTE_W    = 8;           // Data byte width
  localparam int PAGE_SIZE = 1 << PAGE_W; // Bytes in one physical page

  // ==========================================================================
  // Bus framing
  // ==========================================================================
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8; // Fall after eighth rise opens the ack slot
  localparam logic [3:0] BIT_ACK_END  = 4'h9; // Fall after ninth rise closes the byte
  localparam int CTRL_CODE_HI = 7;             // Device type code field, top bit
  localparam int CTRL_CODE_LO = 4;             // Device type code field, bottom bit
  localparam int CTRL_CS_HI   = 3;             // Chip select field, top bit
  localparam int CTRL_CS_LO   = 1;             // Chip select field, bottom bit
  localparam int CTRL_RNW     = 0;             // Read-not-write bit position

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_FREQ_KHZ = 200_000;                  // System clock rate
  localparam int T_WRITE_MS   = 5;                        // Longest self-timed write cycle
  localparam int WR_CYCLES    = T_WRITE_MS * CLK_FREQ_KHZ; // Exact cycle count, no rounding

  // ==========================================================================
  // Types
  // ==========================================================================
  // Pins that cross into the link domain together
  typedef struct packed {
    logic       scl;  // Bus clock
    logic       sda;  // Bus data
    logic       wp;   // Write protect level
    logic [2:0] cs;   // Chip select straps, bit 2 first
  } eep_pins_t;

  // Command phases of the slave
  typedef enum logic [2:0] {
    ST_IDLE,   // Ignoring the bus until a start
    ST_CTRL,   // Receiving the control byte
    ST_ADRH,   // Receiving the high address byte
    ST_ADRL,   // Receiving the low address byte
    ST_WDATA,  // Receiving page data
    ST_RDATA   // Sending read data
  } eep_state_t;

endpackage : eep_pkg

/* File: hdl/eep_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module eep_sync #(
  parameter int WIDTH = 1  // Number of independent levels
) (
  // Destination clock domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

  // Both stages register on every rising clk edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : eep_sync
`default_nettype wire

/* File: hdl/eep_wtimer.sv */
// Self-timed write cycle counter in the system clock domain
`timescale 1ns/1ps
`default_nettype none
module eep_wtimer #(
  parameter int WR_CYCLES = eep_pkg::WR_CYCLES  // Length of one write cycle
) (
  // System clock domain
  input  wire logic clk,
  input  wire logic rst_n,
  // Toggle events, start already synchronised
  input  wire logic start_tgl_s,
  output logic      done_tgl
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  localparam int CNT_W = $clog2(WR_CYCLES + 1);  // Counter width
  if (WR_CYCLES < 1) begin : g_bad_len
    $error("WR_CYCLES must be at least one");
  end

  // ==========================================================================
  // Counter state
  // ==========================================================================
  logic             prev_q, prev_d;  // Last seen start toggle
  logic             run_q, run_d;    // Write cycle in progress
  logic [CNT_W-1:0] cnt_q, cnt_d;    // Cycles still to run
  logic             done_q, done_d;  // Completion toggle

  // Next state: a start edge loads the count, expiry toggles completion
  always_comb begin
    prev_d = start_tgl_s;
    run_d  = run_q;
    cnt_d  = cnt_q;
    done_d = done_q;
    if (start_tgl_s != prev_q) begin
      run_d = 1'b1;
      cnt_d = CNT_W'(WR_CYCLES - 1);
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_d  = 1'b0;        // Busy ends only at expiry [R20]
        done_d = ~done_q;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  // Register the counter state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      run_q  <= 1'b0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      run_q  <= run_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_tgl = done_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_timer_count: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
    (run_q && cnt_q != '0 && start_tgl_s == prev_q) |=> (cnt_q == $past(cnt_q) - 1'b1) && $stable(done_q))
    else $error("write timer skipped a count or ended early");
  chk_timer_expire: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
    (run_q && cnt_q == '0 && start_tgl_s == prev_q) |=> !run_q && (done_q != $past(done_q)))
    else $error("write timer did not signal completion at expiry");

endmodule : eep_wtimer
`default_nettype wire

/* File: hdl/eep_core.sv */
// Two-wire serial EEPROM slave: protection, page wrap, ack polling and reads
//
// Overview of operation
// [R1] Protect input high blocks every array write
// [R2] Protect sampled only at stop of writes
// [R3] Page write stays inside its physical page
// [R4] Master avoids page writes crossing boundaries
// [R5] No acknowledge while the write cycle runs
// [R6] Master polls with start and write control
// [R7] Acknowledge polling control once cycle ends
// [R8] Control byte with read bit starts read
// [R9] Pointer holds last address plus one
// [R10] Current read: ack, one byte, master stops
// [R11] Random read loads pointer before abandonment
// [R12] After random read pointer follows byte
// [R13] Master ack requests next sequential byte
// [R14] Pointer increments after every byte operation
// [R15] Pointer wraps from top to lowest address
// [R16] Page buffer: only low seven bits increment
// [R17] Protected write is acked but changes nothing
// [R18] Respond only on type and select match
// [R19] Two address bytes, high first, sixteen bits
// [R20] Write cycle length is a timed parameter
// [R21] Sample on rise, drive only while low
`timescale 1ns/1ps
`default_nettype none
module eep_core #(
  parameter logic [3:0] DEV_TYPE_CODE = 4'h5,                // Arbitrary value, set per system
  parameter int         ADDR_W        = eep_pkg::ADDR_W,     // Array address width
  parameter int         WR_CYCLES     = eep_pkg::WR_CYCLES   // Write cycle length in clk cycles
) (
  // System clock domain
  input  wire logic clk,
  input  wire logic rst_n,
  // Link clock domain
  input  wire logic link_clk,
  // Two-wire bus, open drain data
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Straps
  input  wire logic wp_i,
  input  wire logic chip_select_bit_2,
  input  wire logic chip_select_bit_1,
  input  wire logic chip_select_bit_0,
  // Status
  output logic      write_busy
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  localparam int PW = eep_pkg::PAGE_W;   // Page offset width
  localparam int HW = ADDR_W - PW;       // Page number width
  if (ADDR_W <= PW || ADDR_W > 16) begin : g_bad_addr
    $error("ADDR_W must lie between PAGE_W+1 and 16");
  end
  // ==========================================================================
  // Crossing into the link and clk domains
  // ==========================================================================
  localparam int SW = $bits(eep_pkg::eep_pins_t) + 1;  // Pins plus done toggle
  eep_pkg::eep_pins_t pins_raw;     // Raw pin levels
  eep_pkg::eep_pins_t pins_s;       // Synchronised pin levels
  logic [SW-1:0]      link_sync_q;  // Synchroniser output
  logic               done_tgl;     // Completion toggle from the timer
  logic               done_s;       // Completion toggle in the link domain
  logic               start_tgl_q;  // Write start toggle, link domain
  logic               start_s;      // Write start toggle in the clk domain
  assign pins_raw = '{scl: scl_i, sda: sda_i, wp: wp_i,
                      cs: {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0}};
  // Pins and the done toggle share one synchroniser into the link domain
  eep_sync #(.WIDTH(SW)) u_link_sync (.clk(link_clk), .rst_n(rst_n), .d({done_tgl, pins_raw}),
                                      .q(link_sync_q));
  assign pins_s = eep_pkg::eep_pins_t'(link_sync_q[SW-2:0]);
  assign done_s = link_sync_q[SW-1];
  // Only toggles cross between clocks, so each event is seen exactly once
  eep_sync #(.WIDTH(1)) u_clk_sync (.clk(clk), .rst_n(rst_n), .d(start_tgl_q), .q(start_s));
  eep_wtimer #(.WR_CYCLES(WR_CYCLES)) u_wtimer (.clk(clk), .rst_n(rst_n), .start_tgl_s(start_s),
                                                .done_tgl(done_tgl));
  // ==========================================================================
  // Bus condition detection
  // ==========================================================================
  logic scl_p_q, sda_p_q, done_p_q;  // One-cycle delayed copies
  logic scl_rise, scl_fall;          // Bus clock edges
  logic start_c, stop_c;             // Start and stop conditions
  logic done_evt;                    // Write cycle finished
  assign scl_rise = pins_s.scl & ~scl_p_q;
  assign scl_fall = ~pins_s.scl & scl_p_q;
  assign start_c  = pins_s.scl & scl_p_q & sda_p_q & ~pins_s.sda;
  assign stop_c   = pins_s.scl & scl_p_q & ~sda_p_q & pins_s.sda;
  assign done_evt = done_s ^ done_p_q;
  // ==========================================================================
  // Storage: array and page buffer, data only, no reset
  // ==========================================================================
  logic [7:0]        mem_q [2**ADDR_W];   // Array
  logic [7:0]        buf_q [eep_pkg::PAGE_SIZE];  // Page buffer
  logic              mem_we, buf_we;      // Write strobes
  logic [ADDR_W-1:0] mem_wa;              // Array write address
  logic [PW-1:0]     buf_wa;              // Buffer write index
  logic [7:0]        buf_wd;              // Buffer write data
  // Array and buffer writes, addressed by index
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= buf_q[mem_wa[PW-1:0]];
    end
    if (buf_we) begin
      buf_q[buf_wa] <= buf_wd;
    end
  end

  // ==========================================================================
  // Command state
  // ==========================================================================
  eep_pkg::eep_state_t st_q, st_d;       // Command phase
  logic [3:0]          cnt_q, cnt_d;     // Clock rises seen in this byte
  logic [7:0]          shift_q, shift_d; // Received bits
  logic [7:0]          tx_q, tx_d;       // Bits still to send
  logic [ADDR_W-1:0]   ptr_q, ptr_d;     // Address pointer
  logic [7:0]          adr_hi_q, adr_hi_d; // High address byte
  logic [HW-1:0]       page_q, page_d;   // Page being written
  logic [eep_pkg::PAGE_SIZE-1:0] vld_q, vld_d; // Buffer entries holding data
  logic                have_q, have_d;   // Write command carries data
  logic                mack_q, mack_d;   // Master acknowledged last byte
  logic                first_q, first_d; // First byte of a read pending
  logic                oe_q, oe_d;       // Pull data low
  logic                busy_q, busy_d;   // Self-timed write running
  logic                drain_q, drain_d; // Buffer moving into the array
  logic [PW-1:0]       didx_q, didx_d;   // Drain index
  logic                start_tgl_d;      // Write start toggle next value
  logic                cs_match;         // Control byte addresses us
  assign cs_match = (shift_q[eep_pkg::CTRL_CODE_HI:eep_pkg::CTRL_CODE_LO] == DEV_TYPE_CODE) &&
                    (shift_q[eep_pkg::CTRL_CS_HI:eep_pkg::CTRL_CS_LO] == pins_s.cs);
  // Next state of the command logic
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    shift_d     = shift_q;
    tx_d        = tx_q;
    ptr_d       = ptr_q;
    adr_hi_d    = adr_hi_q;
    page_d      = page_q;
    vld_d       = vld_q;
    have_d      = have_q;
    mack_d      = mack_q;
    first_d     = first_q;
    oe_d        = oe_q;
    busy_d      = busy_q;
    drain_d     = drain_q;
    didx_d      = didx_q;
    start_tgl_d = start_tgl_q;
    mem_we      = 1'b0;
    mem_wa      = {page_q, didx_q};
    buf_we      = 1'b0;
    buf_wa      = ptr_q[PW-1:0];
    buf_wd      = shift_q;
    // Move one buffered byte per cycle; far shorter than any write cycle
    if (drain_q) begin
      mem_we  = vld_q[didx_q];
      didx_d  = didx_q + 1'b1;
      drain_d = (didx_q != PW'(eep_pkg::PAGE_SIZE - 1));
    end
    // Busy clears only when the timer reports completion; a stop below would win
    busy_d = busy_q && !done_evt;                              // [R20]
    if (start_c || stop_c) begin
      // A start abandons any command with the pointer kept; a stop ends it
      st_d   = start_c ? eep_pkg::ST_CTRL : eep_pkg::ST_IDLE;  // [R11]
      cnt_d  = '0;
      oe_d   = 1'b0;
      have_d = 1'b0;
      // Protect level taken here and nowhere else
      if (stop_c && st_q == eep_pkg::ST_WDATA && have_q && !pins_s.wp) begin   // [R1] [R2] [R17]
        busy_d      = 1'b1;                                    // [R5]
        drain_d     = 1'b1;
        didx_d      = '0;
        start_tgl_d = ~start_tgl_q;
      end
    end else if (scl_rise && st_q != eep_pkg::ST_IDLE) begin
      // Data is taken on the rising bus clock
      if (cnt_q < eep_pkg::BIT_ACK_SLOT) begin
        shift_d = {shift_q[6:0], pins_s.sda};                  // [R21]
      end else begin
        mack_d = ~pins_s.sda;                                  // [R13]
      end
      if (cnt_q != eep_pkg::BIT_ACK_END) begin
        cnt_d = cnt_q + 1'b1;
      end
    end else if (scl_fall && st_q != eep_pkg::ST_IDLE) begin
      // Driven data only changes after a falling bus clock
      if (cnt_q == eep_pkg::BIT_ACK_END) begin
        cnt_d = '0;
        oe_d  = 1'b0;                                          // [R21]
        if (st_q == eep_pkg::ST_RDATA) begin
          if (first_q || mack_q) begin
            tx_d    = mem_q[ptr_q];                            // [R9] [R13]
            oe_d    = ~mem_q[ptr_q][7];
            first_d = 1'b0;
          end else begin
            st_d = eep_pkg::ST_IDLE;                           // [R10] [R13]
          end
        end
      end else if (st_q == eep_pkg::ST_RDATA) begin
        if (cnt_q == eep_pkg::BIT_ACK_SLOT) begin
          oe_d  = 1'b0;                     // Leave the ack slot to the master
          ptr_d = ptr_q + 1'b1;             // Wraps from top to zero [R14] [R15] [R12]
        end else if (cnt_q != '0) begin
          tx_d = {tx_q[6:0], 1'b0};
          oe_d = ~tx_q[6];                                     // [R21]
        end
      end else if (cnt_q == eep_pkg::BIT_ACK_SLOT) begin
        unique case (st_q)
          eep_pkg::ST_CTRL: begin
            // Silence while busy is what the master polls on
            if (cs_match && !busy_q && !drain_q) begin         // [R18] [R5] [R7]
              oe_d    = 1'b1;
              first_d = 1'b1;
              st_d    = shift_q[eep_pkg::CTRL_RNW] ? eep_pkg::ST_RDATA : eep_pkg::ST_ADRH; // [R8]
            end else begin
              st_d = eep_pkg::ST_IDLE;
            end
          end
          eep_pkg::ST_ADRH: begin
            adr_hi_d = shift_q;                                // [R19]
            oe_d     = 1'b1;
            st_d     = eep_pkg::ST_ADRL;
          end
          eep_pkg::ST_ADRL: begin
            ptr_d  = ADDR_W'({adr_hi_q, shift_q});             // [R19] [R11]
            page_d = HW'(ADDR_W'({adr_hi_q, shift_q}) >> PW);
            vld_d  = '0;
            oe_d   = 1'b1;
            st_d   = eep_pkg::ST_WDATA;
          end
          eep_pkg::ST_WDATA: begin
            // Acked even when protected; the stop decides
            buf_we         = 1'b1;                             // [R17]
            vld_d[buf_wa]  = 1'b1;
            have_d         = 1'b1;
            ptr_d          = {ptr_q[ADDR_W-1:PW], ptr_q[PW-1:0] + 1'b1}; // [R3] [R16]
            oe_d           = 1'b1;
          end
          default: begin
            st_d = eep_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end
  // Register the command state
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= eep_pkg::ST_IDLE;
      cnt_q       <= '0;
      shift_q     <= '0;
      tx_q        <= '0;
      ptr_q       <= '0;
      adr_hi_q    <= '0;
      page_q      <= '0;
      vld_q       <= '0;
      have_q      <= 1'b0;
      mack_q      <= 1'b0;
      first_q     <= 1'b0;
      oe_q        <= 1'b0;
      busy_q      <= 1'b0;
      drain_q     <= 1'b0;
      didx_q      <= '0;
      start_tgl_q <= 1'b0;
      scl_p_q     <= 1'b0;
      sda_p_q     <= 1'b0;
      done_p_q    <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      shift_q     <= shift_d;
      tx_q        <= tx_d;
      ptr_q       <= ptr_d;
      adr_hi_q    <= adr_hi_d;
      page_q      <= page_d;
      vld_q       <= vld_d;
      have_q      <= have_d;
      mack_q      <= mack_d;
      first_q     <= first_d;
      oe_q        <= oe_d;
      busy_q      <= busy_d;
      drain_q     <= drain_d;
      didx_q      <= didx_d;
      start_tgl_q <= start_tgl_d;
      scl_p_q     <= pins_s.scl;
      sda_p_q     <= pins_s.sda;
      done_p_q    <= done_s;
    end
  end
  // Open drain: only ever pull low
  assign sda_o      = 1'b0;
  assign sda_oe     = oe_q;
  assign write_busy = busy_q;
  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb_link @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  chk_wp_blocks: assert property ( // [R1] [R17]
    (stop_c && st_q == eep_pkg::ST_WDATA && have_q && pins_s.wp) |=> !drain_q && $stable(start_tgl_q))
    else $error("protected write started a write cycle");
  chk_wp_sample: assert property ( // [R2]
    (stop_c && st_q == eep_pkg::ST_WDATA && have_q && !pins_s.wp) |=> busy_q && drain_q && didx_q == '0)
    else $error("unprotected stop did not start a write cycle");
  chk_page_wrap: assert property ( // [R3] [R16]
    (scl_fall && !start_c && !stop_c && st_q == eep_pkg::ST_WDATA && cnt_q == eep_pkg::BIT_ACK_SLOT)
    |=> $stable(ptr_q[ADDR_W-1:PW]) && ptr_q[PW-1:0] == $past(ptr_q[PW-1:0]) + 1'b1)
    else $error("page write pointer left its page");
  chk_busy_nack: assert property ( // [R5]
    (scl_fall && !start_c && !stop_c && st_q == eep_pkg::ST_CTRL && cnt_q == eep_pkg::BIT_ACK_SLOT && busy_q)
    |=> !oe_q ##1 (st_q == eep_pkg::ST_IDLE))
    else $error("control byte acknowledged while busy");
  chk_rnw_read: assert property ( // [R8]
    (scl_fall && !start_c && !stop_c && st_q == eep_pkg::ST_CTRL && cnt_q == eep_pkg::BIT_ACK_SLOT
     && cs_match && !busy_q && !drain_q && shift_q[eep_pkg::CTRL_RNW]) |=> st_q == eep_pkg::ST_RDATA && oe_q)
    else $error("read control byte did not start a read");
  chk_ptr_incr: assert property ( // [R14] [R15]
    (scl_fall && !start_c && !stop_c && st_q == eep_pkg::ST_RDATA && cnt_q == eep_pkg::BIT_ACK_SLOT)
    |=> ptr_q == $past(ptr_q) + 1'b1 && !oe_q)
    else $error("read pointer did not advance by one");
  chk_adr_load: assert property ( // [R11] [R19]
    (scl_fall && !start_c && !stop_c && st_q == eep_pkg::ST_ADRL && cnt_q == eep_pkg::BIT_ACK_SLOT)
    |=> ptr_q == ADDR_W'({$past(adr_hi_q), $past(shift_q)}))
    else $error("word address not loaded high byte first");
  chk_drive_low: assert property ( // [R21]
    $rose(oe_q) |-> $past(scl_fall) && !pins_s.scl)
    else $error("data pulled low outside the bus clock low phase");
  chk_nack_ends: assert property ( // [R10] [R13]
    (scl_fall && !start_c && !stop_c && st_q == eep_pkg::ST_RDATA && cnt_q == eep_pkg::BIT_ACK_END
     && !first_q && !mack_q) |=> st_q == eep_pkg::ST_IDLE && !oe_q)
    else $error("transmission continued after master withheld ack");

endmodule : eep_core
`default_nettype wire

/* File: tb/eep_mst.sv */
// Bit-level two-wire bus master model
`timescale 1ns/1ps
`default_nettype none
module eep_mst (
  // Bench clock, paces the bus
  input  wire logic clk,
  // Bus lines
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  // ==========================================================================
  // Bus phases
  // ==========================================================================
  initial begin
    scl    = 1'h1;  // Clock stands high between frames
    sda_oe = 1'h0;  // Released, pull-up holds high
  end
  // One 60 ns phase, far above the slave's sync latency
  task automatic ph;
    repeat (12) @(posedge clk);
    #1;
  endtask : ph
  // Data changes only with clock low
  task automatic bit1(input logic b, output logic r);
    sda_oe = ~b;
    ph();
    scl = 1'h1;
    ph();
    r   = sda;  // Late in the high phase, slave data has settled
    scl = 1'h0;
    ph();
  endtask : bit1
  // Start, also usable as a repeated start
  task automatic start;
    sda_oe = 1'h0;
    ph();
    scl = 1'h1;
    ph();
    sda_oe = 1'h1;
    ph();
    scl = 1'h0;
    ph();
  endtask : start
  task automatic stop;
    sda_oe = 1'h1;
    ph();
    scl = 1'h1;
    ph();
    sda_oe = 1'h0;
    ph();
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(d[i], r);
    bit1(1'h1, r);
    ack = ~r;
  endtask : wbyte
  // Master acks to go on, nacks on the last byte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(1'h1, d[i]);
    bit1(~ack, r);
  endtask : rbyte
endmodule : eep_mst
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam logic [6:0] DEV = 7'h2B;  // Type code 4'h5, straps 3'h3
  logic clk;
  logic link_clk;
  logic rst_n;
  logic wp;
  logic m_scl;
  logic m_oe;
  logic sda_o;
  logic sda_oe;
  logic busy;
  wire  sda = ~(sda_oe | m_oe);  // Open drain with pull-up
  int   num_errors;
  int   checks;
  // Write cycle must outlast the busy probe, whose ack slot comes about 1.7 us after the stop
  eep_core #(.ADDR_W(10), .WR_CYCLES(2000)) i_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .scl_i(m_scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp), .chip_select_bit_2(1'h0),
    .chip_select_bit_1(1'h1), .chip_select_bit_0(1'h1), .write_busy(busy));
  eep_mst i_mst (.clk(clk), .scl(m_scl), .sda_oe(m_oe), .sda(sda));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #1.3;
    forever #3 link_clk = ~link_clk;  // Unrelated phase
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    i_mst.wbyte(d, a);
    chk({7'h0, a}, {7'h0, e});
  endtask : wb
  // Write header, high address byte first
  task automatic adr(input logic [15:0] a);
    i_mst.start();
    wb({DEV, 1'h0}, 1'h1);
    wb(a[15:8], 1'h1);
    wb(a[7:0], 1'h1);
  endtask : adr
  task automatic rd(input logic [7:0] e0, input logic two, input logic [7:0] e1);
    logic [7:0] d;
    i_mst.start();
    wb({DEV, 1'h1}, 1'h1);
    i_mst.rbyte(two, d);
    chk(d, e0);
    if (two) begin
      i_mst.rbyte(1'h0, d);
      chk(d, e1);
    end
    i_mst.stop();
  endtask : rd
  task automatic poll;
    logic a;
    for (int i = 0; i < 80; i++) begin
      i_mst.start();
      i_mst.wbyte({DEV, 1'h0}, a);
      i_mst.stop();
      if (a === 1'h1) return;
    end
    chk(8'hEE, 8'h00);  // Write cycle never ended
    end_sim();
  endtask : poll
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_page;
    adr(16'h007E);
    for (int i = 0; i < 4; i++) wb(8'hA1 + 8'(i * 17), 1'h1);
    i_mst.stop();
    wp = 1'h1;  // Late protect must not cancel the cycle
    chk({7'h0, busy}, 8'h01);
    i_mst.start();
    wb({DEV, 1'h0}, 1'h0);
    i_mst.stop();
    wp = 1'h0;
    poll();
    adr(16'h0000);
    rd(8'hC3, 1'h0, 8'h00);
    rd(8'hD4, 1'h0, 8'h00);
    adr(16'h007E);
    rd(8'hA1, 1'h1, 8'hB2);
  endtask : t_page
  task automatic t_prot_cs;
    wp = 1'h1;
    adr(16'h007E);
    wb(8'h55, 1'h1);
    i_mst.stop();
    wp = 1'h0;
    chk({7'h0, busy}, 8'h00);
    adr(16'h007E);
    rd(8'hA1, 1'h0, 8'h00);
    i_mst.start();
    wb({7'h2A, 1'h1}, 1'h0);
    i_mst.start();
    wb({7'h33, 1'h1}, 1'h0);
    i_mst.stop();
    adr(16'h03FF);
    wb(8'hE7, 1'h1);  // One byte, stays inside its page
    i_mst.stop();
    poll();
    adr(16'h03FF);
    rd(8'hE7, 1'h1, 8'hC3);
    chk({7'h0, sda_o}, 8'h00);  // Open drain never drives high
  endtask : t_prot_cs
  initial begin
    num_errors = 0;
    checks     = 0;
    rst_n      = 1'h0;
    wp         = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'h1;
    repeat (8) @(posedge clk);
    t_page();
    t_prot_cs();
    end_sim();
  end
endmodule : tb
`default_nettype wire
